// ### rtl/mft_top.sv
// Multi-function terminal logic with classic Wishbone register slave
//
// Chosen here: the register offsets and register access over Wishbone.
`default_nettype none
module mft_top #(
	parameter int N_IN = 8,
	parameter longint HOLD_CYC = mft_pkg::HOLD_CYCLES,
	parameter longint SEARCH_CYC = mft_pkg::SEARCH_CYCLES
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	// Wishbone classic slave
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	// Field terminals, closed is high
	input wire logic [N_IN-1:0] term_in,
	output logic [3:0] term_out,
	// Control core status
	input wire logic run_cmd,
	input wire logic jog_cmd,
	input wire logic running,
	input wire logic decelerating,
	input wire logic dc_braking,
	input wire logic zero_speed,
	input wire logic speed_agree,
	input wire logic drive_ready,
	input wire logic undervoltage,
	input wire logic baseblock,
	input wire logic fault,
	input wire logic alarm,
	input wire logic timer_done,
	input wire logic zero_servo_done,
	input wire logic brake_ctrl,
	input wire logic power_loss,
	input wire logic [11:0] analog_input_one,
	input wire logic [11:0] analog_input_two,
	// Commands to the control core
	output logic [15:0] freq_command,
	output logic run_permit,
	output logic stop_request,
	output logic [1:0] stopping_method_select,
	output logic timer_start,
	output logic kinetic_energy_buffering,
	output logic [1:0] buffering_method_select,
	output logic speed_search_from_cmd,
	output logic dc_brake_request,
	output logic torque_mode,
	output logic ref_hold,
	output logic zero_servo_request,
	output logic disabled_indication,
	output logic hold_conflict_error,
	output logic control_method_error
);
	import mft_pkg::*;

	localparam logic [27:0] HOLD_N = 28'(HOLD_CYC);
	localparam logic [27:0] SEARCH_N = 28'(SEARCH_CYC);

	if (N_IN < 1 || N_IN > 8) begin : g_chk_in
		$error("mft_top supports one to eight input terminals");
	end
	if (HOLD_CYC < 1 || HOLD_CYC > 268435455) begin : g_chk_hold
		$error("mft_top hold count out of range");
	end
	if (SEARCH_CYC < 1 || SEARCH_CYC > 268435455) begin : g_chk_srch
		$error("mft_top search count out of range");
	end

	typedef struct packed {
		logic ack;
		logic [31:0] dat;
		logic [3:0][7:0] osel;
		logic [7:0][7:0] isel;
		logic freq_src;
		logic buf_nc;
		logic [1:0] bufm;
		logic [2:0] cmeth;
		logic [1:0] stopm;
		logic [15:0] swdly;
		logic [2:0][15:0] offs;
		logic [15:0] fmon;
		logic [27:0] hold_cnt;
		logic [15:0] held;
		logic held_ok;
		logic [27:0] srch_cnt;
		logic srch;
		mft_run_t run_st;
		logic tq;
		logic [15:0] sw_cnt;
		logic ref_hold;
		logic [3:0] tout;
		logic [15:0] freq;
		logic stop_req;
		logic timer_start;
		logic ebuf;
		logic dcb;
		logic zs_req;
		logic dis;
		logic e_hold;
		logic e_ctl;
	} mft_state_t;

	mft_state_t s_r;
	mft_state_t s_nxt;
	logic [N_IN-1:0] tin;

	////////////////////////////////////////////////////////////////////////
	// Field inputs come from another domain, so they are filtered first
	mft_sync #(.WIDTH(N_IN)) u_sync (
		.clk(clk),
		.reset(reset),
		.ce(ce),
		.din(term_in),
		.dout(tin)
	);

	////////////////////////////////////////////////////////////////////////
	// Mask of input terminals assigned a given function code
	function automatic logic [7:0] assigned(input logic [7:0][7:0] sel,
			input logic [7:0] code);
		logic [7:0] m;
		m = '0;
		for (int i = 0; i < N_IN; i++) begin
			m[i] = (sel[i] == code);
		end
		return m;
	endfunction

	// Byte-lane merge of a Wishbone write into a word
	function automatic logic [31:0] merge(input logic [31:0] old,
			input logic [31:0] wd, input logic [3:0] sel);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				r[b*8 +: 8] = wd[b*8 +: 8];
			end
		end
		return r;
	endfunction

	// Terminal level for one output selector
	function automatic logic out_level(input logic [7:0] sel,
			input logic [31:0] src);
		logic [7:0] base;
		logic inv;
		logic lvl;
		inv = (sel >= OUT_INVERT);
		base = inv ? 8'(sel - OUT_INVERT) : sel;
		lvl = 1'b0;
		if (base <= OUT_LAST) begin
			case (base)
				OUT_RUN: lvl = src[0];
				OUT_ZERO_SPEED: lvl = src[1];
				OUT_AGREE: lvl = src[2];
				OUT_READY: lvl = src[3];
				OUT_UNDERVOLT: lvl = src[4];
				OUT_BASEBLOCK: lvl = src[5];
				OUT_FAULT: lvl = src[6];
				OUT_ALARM: lvl = src[7];
				OUT_TIMER: lvl = src[8];
				OUT_ZS_DONE: lvl = src[9];
				OUT_ENABLED: lvl = src[10];
				OUT_BRAKE: lvl = src[11];
				default: return 1'b0;
			endcase
			return lvl ^ inv;
		end
		return 1'b0;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Decoded terminal functions, an unassigned enable counts as closed
	logic [7:0] tin8;
	logic f_lock_ok;
	logic f_enable;
	logic f_hold;
	logic f_search;
	logic f_dcb;
	logic f_tq;
	logic f_zs;
	logic [2:0] f_offs;
	logic [31:0] osrc;
	logic [17:0] fsum;
	logic [15:0] fbase;
	logic [31:0] rd;
	logic wr;

	assign tin8 = 8'(tin);
	assign f_lock_ok = ~|assigned(s_r.isel, IN_LOCKOUT) |
		|(assigned(s_r.isel, IN_LOCKOUT) & tin8);
	assign f_enable = ~|assigned(s_r.isel, IN_ENABLE) |
		|(assigned(s_r.isel, IN_ENABLE) & tin8);
	assign f_hold = |(assigned(s_r.isel, IN_ANALOG_HOLD) & tin8);
	assign f_search = |(assigned(s_r.isel, IN_SEARCH) & tin8);
	assign f_dcb = |(assigned(s_r.isel, IN_DC_BRAKE) & tin8);
	assign f_tq = |(assigned(s_r.isel, IN_TQ_SWITCH) & tin8);
	assign f_zs = |(assigned(s_r.isel, IN_ZERO_SERVO) & tin8);
	assign f_offs[0] = |(assigned(s_r.isel, IN_OFFSET_ONE) & tin8);
	assign f_offs[1] = |(assigned(s_r.isel, IN_OFFSET_TWO) & tin8);
	assign f_offs[2] = |(assigned(s_r.isel, IN_OFFSET_THREE) & tin8);
	assign wr = wb_cyc_i & wb_stb_i & wb_we_i & ~s_r.ack;

	// Status sources in output-function order
	assign osrc = {20'h00000, brake_ctrl, f_enable,
		zero_servo_done & s_r.zs_req, timer_done, alarm, fault,
		baseblock, undervoltage, drive_ready, speed_agree, zero_speed,
		run_cmd | dc_braking | decelerating};

	// Base command plus offsets, saturated to sixteen bits
	always_comb begin
		fbase = s_r.freq_src ? s_r.fmon :
			16'(analog_input_one) + 16'(analog_input_two);
		if (s_r.held_ok) begin
			fbase = s_r.held;
		end
		fsum = 18'(fbase);
		for (int k = 0; k < 3; k++) begin
			if (f_offs[k]) begin
				fsum = fsum + 18'(s_r.offs[k]);
			end
		end
	end

	// Read multiplexer, unmapped offsets read zero
	always_comb begin
		case (wb_adr_i)
			OFS_RELAY_ONE: rd = {24'h000000, s_r.osel[0]};
			OFS_RELAY_TWO: rd = {24'h000000, s_r.osel[1]};
			OFS_OC_ONE: rd = {24'h000000, s_r.osel[2]};
			OFS_OC_TWO: rd = {24'h000000, s_r.osel[3]};
			OFS_IN_SEL_LO: rd = s_r.isel[3:0];
			OFS_IN_SEL_HI: rd = s_r.isel[7:4];
			OFS_CTRL: rd = {23'h000000, s_r.stopm, s_r.cmeth,
				s_r.bufm, s_r.buf_nc, s_r.freq_src};
			OFS_SW_DELAY: rd = {16'h0000, s_r.swdly};
			OFS_OFFSET_ONE: rd = {16'h0000, s_r.offs[0]};
			OFS_OFFSET_TWO: rd = {16'h0000, s_r.offs[1]};
			OFS_OFFSET_THREE: rd = {16'h0000, s_r.offs[2]};
			OFS_STATUS: rd = {13'h0000, s_r.srch, s_r.ref_hold, s_r.tq,
				s_r.held_ok, s_r.dis, s_r.e_ctl, s_r.e_hold,
				s_r.tout, tin8};
			OFS_FREQ_MON: rd = {16'h0000, s_r.fmon};
			OFS_FREQ_ACT: rd = {16'h0000, s_r.freq};
			default: rd = 32'h00000000;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Next-state logic of the whole block
	always_comb begin
		logic [31:0] w;
		logic [7:0] conf;
		w = 32'h00000000;
		conf = '0;
		s_nxt = s_r;

		// Bus slave: ack one cycle after the strobe, dropped after
		s_nxt.ack = wb_cyc_i & wb_stb_i & ~s_r.ack;
		s_nxt.dat = rd;
		if (wr) begin
			w = merge(rd, wb_dat_i, wb_sel_i);
			if (wb_adr_i == OFS_FREQ_MON) begin
				s_nxt.fmon = w[15:0];
			end else if (f_lock_ok) begin
				case (wb_adr_i)
					OFS_RELAY_ONE: s_nxt.osel[0] = w[7:0];
					OFS_RELAY_TWO: s_nxt.osel[1] = w[7:0];
					OFS_OC_ONE: s_nxt.osel[2] = w[7:0];
					OFS_OC_TWO: s_nxt.osel[3] = w[7:0];
					OFS_IN_SEL_LO: s_nxt.isel[3:0] = w;
					OFS_IN_SEL_HI: s_nxt.isel[7:4] = w;
					OFS_CTRL: begin
						s_nxt.freq_src = w[CTRL_FREQ_SRC];
						s_nxt.buf_nc = w[CTRL_BUF_NC];
						if (w[CTRL_BUF_LSB +: 2] <= BUF_METHOD_MAX) begin
							s_nxt.bufm = w[CTRL_BUF_LSB +: 2];
						end
						s_nxt.cmeth = w[CTRL_CM_LSB +: 3];
						s_nxt.stopm = w[CTRL_CM_LSB+3 +: 2];
					end
					OFS_SW_DELAY: s_nxt.swdly = w[15:0];
					OFS_OFFSET_ONE: s_nxt.offs[0] = w[15:0];
					OFS_OFFSET_TWO: s_nxt.offs[1] = w[15:0];
					OFS_OFFSET_THREE: s_nxt.offs[2] = w[15:0];
					default: s_nxt.dat = rd;
				endcase
			end
		end

		// Analog hold: closed for the hold time samples the command
		if (f_hold) begin
			if (s_r.hold_cnt < HOLD_N) begin
				s_nxt.hold_cnt = s_r.hold_cnt + 28'h0000001;
			end
			if (s_r.hold_cnt == HOLD_N - 28'h0000001) begin
				s_nxt.held = 16'(analog_input_one) +
					16'(analog_input_two);
				s_nxt.held_ok = 1'b1;
			end
		end else begin
			s_nxt.hold_cnt = '0;
		end

		// Search input closed time, saturating
		if (f_search) begin
			if (s_r.srch_cnt < SEARCH_N) begin
				s_nxt.srch_cnt = s_r.srch_cnt + 28'h0000001;
			end
		end else begin
			s_nxt.srch_cnt = '0;
		end

		// Run permission: enable must close with run absent
		s_nxt.stop_req = 1'b0;
		case (s_r.run_st)
			MFT_WAIT: begin
				if (f_enable && !run_cmd) begin
					s_nxt.run_st = MFT_ARMED;
				end
			end
			MFT_ARMED: begin
				if (!f_enable) begin
					s_nxt.run_st = MFT_WAIT;
				end else if (run_cmd) begin
					s_nxt.run_st = MFT_RUN;
					s_nxt.srch = (s_r.srch_cnt >= SEARCH_N);
				end
			end
			MFT_RUN: begin
				if (!f_enable) begin
					s_nxt.run_st = MFT_STOP;
					s_nxt.stop_req = 1'b1;
				end else if (!run_cmd) begin
					s_nxt.run_st = MFT_ARMED;
				end
			end
			MFT_STOP: begin
				s_nxt.stop_req = running;
				if (!running) begin
					s_nxt.run_st = MFT_WAIT;
				end
			end
			default: s_nxt.run_st = MFT_WAIT;
		endcase
		if (s_nxt.run_st != MFT_RUN) begin
			s_nxt.srch = 1'b0;
		end

		// Torque switch waits out the delay holding references
		s_nxt.ref_hold = 1'b0;
		if (f_tq != s_r.tq) begin
			if (s_r.sw_cnt < s_r.swdly) begin
				s_nxt.sw_cnt = s_r.sw_cnt + 16'h0001;
				s_nxt.ref_hold = 1'b1;
			end else begin
				s_nxt.tq = f_tq;
				s_nxt.sw_cnt = '0;
			end
		end else begin
			s_nxt.sw_cnt = '0;
		end

		// Configuration conflicts
		conf = assigned(s_r.isel, IN_RAMP_HOLD) |
			assigned(s_r.isel, IN_UP) | assigned(s_r.isel, IN_DOWN) |
			assigned(s_r.isel, IN_UP2) | assigned(s_r.isel, IN_DOWN2) |
			assigned(s_r.isel, IN_OFFSET_ONE) |
			assigned(s_r.isel, IN_OFFSET_TWO) |
			assigned(s_r.isel, IN_OFFSET_THREE);
		s_nxt.e_hold = |assigned(s_r.isel, IN_ANALOG_HOLD) & |conf;
		s_nxt.e_ctl = |assigned(s_r.isel, IN_TQ_SWITCH) &
			(s_r.cmeth != CM_TORQUE_A) & (s_r.cmeth != CM_TORQUE_B);

		// Plain terminal functions
		s_nxt.timer_start = |(assigned(s_r.isel, IN_TIMER) & tin8) &
			(s_r.osel[0] == OUT_TIMER || s_r.osel[1] == OUT_TIMER ||
			s_r.osel[2] == OUT_TIMER || s_r.osel[3] == OUT_TIMER);
		s_nxt.ebuf = |assigned(s_r.isel, IN_EBUF) &
			(|(assigned(s_r.isel, IN_EBUF) & tin8) ^ s_r.buf_nc);
		s_nxt.dcb = f_dcb & decelerating & ~run_cmd & ~jog_cmd;
		s_nxt.zs_req = f_zs & run_cmd;
		s_nxt.dis = ~f_enable;
		s_nxt.freq = (fsum > 18'h0FFFF) ? 16'hFFFF : fsum[15:0];
		for (int t = 0; t < 4; t++) begin
			s_nxt.tout[t] = out_level(s_r.osel[t], osrc);
		end

		// Loss of power drops the held and active command
		if (power_loss) begin
			s_nxt.held = '0;
			s_nxt.held_ok = 1'b0;
			s_nxt.hold_cnt = '0;
			s_nxt.freq = '0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Single state register, frozen while the clock enable is low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_r <= '0;
			s_r.osel[0] <= RST_RELAY_ONE;
			s_r.osel[1] <= RST_RELAY_TWO;
			s_r.osel[2] <= RST_OC_ONE;
			s_r.osel[3] <= RST_OC_TWO;
			s_r.isel <= {8{RST_IN_SEL}};
			s_r.cmeth <= RST_CTRL_METHOD;
			s_r.run_st <= MFT_WAIT;
			s_r.dis <= 1'b1;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	// Outputs straight from the state register
	assign wb_ack_o = s_r.ack;
	assign wb_dat_o = s_r.dat;
	assign term_out = s_r.tout;
	assign freq_command = s_r.freq;
	assign run_permit = (s_r.run_st == MFT_RUN);
	assign stop_request = s_r.stop_req;
	assign stopping_method_select = s_r.stopm;
	assign timer_start = s_r.timer_start;
	assign kinetic_energy_buffering = s_r.ebuf;
	assign buffering_method_select = s_r.bufm;
	assign speed_search_from_cmd = s_r.srch;
	assign dc_brake_request = s_r.dcb;
	assign torque_mode = s_r.tq;
	assign ref_hold = s_r.ref_hold;
	assign zero_servo_request = s_r.zs_req;
	assign disabled_indication = s_r.dis;
	assign hold_conflict_error = s_r.e_hold;
	assign control_method_error = s_r.e_ctl;
endmodule
`default_nettype wire

// ### rtl/mft_pkg.sv
// Package: register map, function codes and timing of the terminal logic
// Contract
// - Timer input pairs with timer output terminal
// - Closed offset input adds its offset frequency
// - Buffering enable by contact sense, method 0-2
// - Lockout open rejects writes except frequency monitor
// - Hold closed 100ms samples analog command
// - Power loss clears held command to zero
// - Hold with ramp/updown/offset gives conflict error
// - Search input closed 1s starts search
// - DC brake in deceleration, removed by run/jog
// - No run until enable closes; show disabled
// - Run present at enable needs recycling
// - Enable opening during run requests stop
// - Switch closed torque control, open speed control
// - Switch needs control method 3 or 5
// - Hold references during switch delay
// - Zero servo needs run; completion drops
// - Four output terminals with function selectors
// - Hundreds digit one inverts output sense
// - Output codes map to drive status
// - Code zero closes on run, braking, decel
`default_nettype none
package mft_pkg;
	////////////////////////////////////////////////////////////////////////
	// Register byte offsets
	localparam logic [7:0] OFS_RELAY_ONE = 8'h00;
	localparam logic [7:0] OFS_RELAY_TWO = 8'h04;
	localparam logic [7:0] OFS_OC_ONE = 8'h08;
	localparam logic [7:0] OFS_OC_TWO = 8'h0C;
	localparam logic [7:0] OFS_IN_SEL_LO = 8'h10;
	localparam logic [7:0] OFS_IN_SEL_HI = 8'h14;
	localparam logic [7:0] OFS_CTRL = 8'h18;
	localparam logic [7:0] OFS_SW_DELAY = 8'h1C;
	localparam logic [7:0] OFS_OFFSET_ONE = 8'h20;
	localparam logic [7:0] OFS_OFFSET_TWO = 8'h24;
	localparam logic [7:0] OFS_OFFSET_THREE = 8'h28;
	localparam logic [7:0] OFS_STATUS = 8'h2C;
	localparam logic [7:0] OFS_FREQ_MON = 8'h30;
	localparam logic [7:0] OFS_FREQ_ACT = 8'h34;
	// Control register fields
	localparam int CTRL_FREQ_SRC = 0;
	localparam int CTRL_BUF_NC = 1;
	localparam int CTRL_BUF_LSB = 2;
	localparam int CTRL_CM_LSB = 4;
	// Reset values of the output and input selectors and the control method
	localparam logic [7:0] RST_RELAY_ONE = 8'h00;
	localparam logic [7:0] RST_RELAY_TWO = 8'h0B;
	localparam logic [7:0] RST_OC_ONE = 8'h01;
	localparam logic [7:0] RST_OC_TWO = 8'h02;
	localparam logic [7:0] RST_IN_SEL = 8'h00;
	localparam logic [2:0] RST_CTRL_METHOD = 3'h0;
	////////////////////////////////////////////////////////////////////////
	// Input function codes
	localparam logic [7:0] IN_UP = 8'h0A;
	localparam logic [7:0] IN_DOWN = 8'h0B;
	localparam logic [7:0] IN_UP2 = 8'h0C;
	localparam logic [7:0] IN_DOWN2 = 8'h0D;
	localparam logic [7:0] IN_RAMP_HOLD = 8'h12;
	localparam logic [7:0] IN_TIMER = 8'h34;
	localparam logic [7:0] IN_OFFSET_ONE = 8'h35;
	localparam logic [7:0] IN_OFFSET_TWO = 8'h36;
	localparam logic [7:0] IN_OFFSET_THREE = 8'h37;
	localparam logic [7:0] IN_EBUF = 8'h39;
	localparam logic [7:0] IN_LOCKOUT = 8'h3C;
	localparam logic [7:0] IN_ANALOG_HOLD = 8'h3D;
	localparam logic [7:0] IN_SEARCH = 8'h3F;
	localparam logic [7:0] IN_DC_BRAKE = 8'h41;
	localparam logic [7:0] IN_ENABLE = 8'h45;
	localparam logic [7:0] IN_TQ_SWITCH = 8'h46;
	localparam logic [7:0] IN_ZERO_SERVO = 8'h47;
	// Output function codes
	localparam logic [7:0] OUT_INVERT = 8'h64;
	localparam logic [7:0] OUT_LAST = 8'h31;
	localparam logic [7:0] OUT_RUN = 8'h00;
	localparam logic [7:0] OUT_ZERO_SPEED = 8'h01;
	localparam logic [7:0] OUT_AGREE = 8'h02;
	localparam logic [7:0] OUT_READY = 8'h04;
	localparam logic [7:0] OUT_UNDERVOLT = 8'h05;
	localparam logic [7:0] OUT_BASEBLOCK = 8'h06;
	localparam logic [7:0] OUT_FAULT = 8'h0B;
	localparam logic [7:0] OUT_ALARM = 8'h0D;
	localparam logic [7:0] OUT_TIMER = 8'h0F;
	localparam logic [7:0] OUT_ZS_DONE = 8'h22;
	localparam logic [7:0] OUT_ENABLED = 8'h24;
	localparam logic [7:0] OUT_BRAKE = 8'h31;
	// Control methods that allow the torque switch, and the highest buffering method
	localparam logic [2:0] CM_TORQUE_A = 3'h3;
	localparam logic [2:0] CM_TORQUE_B = 3'h5;
	localparam logic [1:0] BUF_METHOD_MAX = 2'h2;
	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam longint CLK_HZ = 200000000;
	localparam longint HOLD_TIME_MS = 100;
	localparam longint SEARCH_TIME_MS = 1000;
	localparam longint HOLD_CYCLES = CLK_HZ / 1000 * HOLD_TIME_MS;
	localparam longint SEARCH_CYCLES = CLK_HZ / 1000 * SEARCH_TIME_MS;
	// Run permission sequence, Gray coded
	typedef enum logic [1:0] {
		MFT_WAIT = 2'h0,
		MFT_ARMED = 2'h1,
		MFT_RUN = 2'h3,
		MFT_STOP = 2'h2
	} mft_run_t;
endpackage
`default_nettype wire

// ### rtl/mft_sync.sv
// Three-stage synchroniser with agreement filter for terminal inputs
`default_nettype none
module mft_sync #(
	parameter int WIDTH = 8
) (
	input wire logic clk,
	input wire logic reset,
	input wire logic ce,
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	import mft_pkg::*;

	typedef struct packed {
		logic [WIDTH-1:0] s1;
		logic [WIDTH-1:0] s2;
		logic [WIDTH-1:0] s3;
		logic [WIDTH-1:0] q;
	} mft_sync_t;

	mft_sync_t s_r;
	mft_sync_t s_nxt;

	if (WIDTH < 1) begin : g_chk
		$error("mft_sync width must be at least one");
	end

	////////////////////////////////////////////////////////////////////////
	// Only stage two and three feed the filter, stage one stays private
	always_comb begin
		s_nxt = s_r;
		s_nxt.s1 = din;
		s_nxt.s2 = s_r.s1;
		s_nxt.s3 = s_r.s2;
		for (int i = 0; i < WIDTH; i++) begin
			if (s_r.s2[i] == s_r.s3[i]) begin
				s_nxt.q[i] = s_r.s3[i];
			end
		end
	end

	// State register, frozen while the clock enable is low
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			s_r <= '0;
		end else if (ce) begin
			s_r <= s_nxt;
		end
	end

	assign dout = s_r.q;
endmodule
`default_nettype wire

// ### testbench/mft_core_model.sv
// Behavioural model of the drive control core beside the terminal logic
`default_nettype none
module mft_core_model (
	input wire logic clk,
	input wire logic reset,
	input wire logic run_permit,
	input wire logic stop_request,
	output logic running,
	output logic decelerating
);
	timeunit 1ns;
	timeprecision 100ps;
	int ramp;
	////////////////////////////////////////////////////////////////////////
	// Motor starts only when permitted; keeps turning 13 cycles after, as a real one ramps down
	always_ff @(posedge clk or posedge reset) begin
		if (reset) begin
			running <= 1'b0;
			ramp <= 0;
		end else if (run_permit) begin
			running <= 1'b1;
			ramp <= 12;
		end else if (ramp > 0) begin
			ramp <= ramp - 1;
		end else begin
			running <= 1'b0;
		end
	end
	// Decelerating whenever turning without permission
	assign decelerating = running && !run_permit && !stop_request ? 1'b1 :
		running && !run_permit;
endmodule
`default_nettype wire

// ### testbench/mft_top_asserts.sv
// Concurrent checks on the ports of the terminal logic
`default_nettype none
module mft_top_chk (
	input wire logic clk,
	input wire logic reset,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_ack_o,
	input wire logic run_cmd,
	input wire logic jog_cmd,
	input wire logic power_loss,
	input wire logic [15:0] freq_command,
	input wire logic run_permit,
	input wire logic stop_request,
	input wire logic [1:0] buffering_method_select,
	input wire logic speed_search_from_cmd,
	input wire logic dc_brake_request,
	input wire logic zero_servo_request,
	input wire logic disabled_indication,
	input wire logic hold_conflict_error
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////////////
	// Bus, brake, power and servo outputs tied to their cause one edge earlier, as is the disabled check through $past, the rest in the same cycle
	bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
		|=> wb_ack_o ##1 !wb_ack_o) else $error("ack not one pulse");
	brake_drop_a: assert property ((run_cmd || jog_cmd)
		|=> !dc_brake_request) else $error("dc brake kept in run");
	power_zero_a: assert property (power_loss
		|=> freq_command == 16'h0000) else $error("freq not zero");
	disabled_run_a: assert property ($rose(run_permit)
		|-> $past(disabled_indication) == 1'b0) else $error("run while off");
	stop_perm_a: assert property (stop_request
		|-> !run_permit) else $error("permit kept on stop");
	servo_run_a: assert property (!run_cmd
		|=> !zero_servo_request) else $error("servo without run");
	buf_range_a: assert property (buffering_method_select
		!= 2'h3) else $error("buffering method out of range");
	search_run_a: assert property (speed_search_from_cmd
		|-> run_permit) else $error("search flag outside run");
	// Main scenarios reached
	cover property ($rose(run_permit));
	cover property ($rose(stop_request));
	cover property ($rose(hold_conflict_error));
endmodule
bind mft_top mft_top_chk chk_u (.clk, .reset, .wb_cyc_i, .wb_stb_i,
	.wb_ack_o, .run_cmd, .jog_cmd, .power_loss, .freq_command, .run_permit,
	.stop_request, .buffering_method_select, .speed_search_from_cmd,
	.dc_brake_request, .zero_servo_request, .disabled_indication,
	.hold_conflict_error);
`default_nettype wire

// ### testbench/tb_multifunction_terminal_logic.sv
// Self-checking bench of the multi-function terminal logic
`default_nettype none
module tb_multifunction_terminal_logic;
	timeunit 1ns;
	timeprecision 100ps;
	import mft_pkg::*;
	localparam logic [7:0] CD [9] = '{OUT_ZERO_SPEED, OUT_AGREE, OUT_READY,
		OUT_UNDERVOLT, OUT_BASEBLOCK, OUT_FAULT, OUT_ALARM, OUT_TIMER,
		OUT_BRAKE};
	logic clk, reset, ce, cyc, stb, we, ack, run_cmd, jog_cmd, running;
	logic decelerating, dc_braking, zero_servo_done, power_loss, run_permit;
	logic stop_request, timer_start, kinetic_energy_buffering, ref_hold;
	logic speed_search_from_cmd, dc_brake_request, torque_mode;
	logic zero_servo_request, disabled_indication, hold_conflict_error;
	logic control_method_error;
	logic [31:0] dwr, dato, rdat;
	logic [7:0] adr, term_in;
	logic [3:0] sel, term_out;
	logic [8:0] sts;
	logic [11:0] analog_input_one, analog_input_two;
	logic [15:0] freq_command;
	logic [1:0] stopping_method_select, buffering_method_select;
	int errors, checks_done;
	mft_top #(.HOLD_CYC(20), .SEARCH_CYC(40)) dut_u (.clk, .reset, .ce,
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
		.wb_sel_i(sel), .wb_dat_i(dwr), .wb_dat_o(dato), .wb_ack_o(ack),
		.term_in, .term_out, .run_cmd, .jog_cmd, .running, .decelerating,
		.dc_braking, .zero_speed(sts[0]), .speed_agree(sts[1]),
		.drive_ready(sts[2]), .undervoltage(sts[3]), .baseblock(sts[4]),
		.fault(sts[5]), .alarm(sts[6]), .timer_done(sts[7]),
		.zero_servo_done, .brake_ctrl(sts[8]), .power_loss,
		.analog_input_one, .analog_input_two, .freq_command, .run_permit,
		.stop_request, .stopping_method_select, .timer_start,
		.kinetic_energy_buffering, .buffering_method_select,
		.speed_search_from_cmd, .dc_brake_request, .torque_mode, .ref_hold,
		.zero_servo_request, .disabled_indication, .hold_conflict_error,
		.control_method_error);
	mft_core_model model_u (.clk, .reset, .run_permit, .stop_request,
		.running, .decelerating);
	////////////////////////////////////////////////////////////////////////
	// Clock at 200 MHz
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// Counting compare; unknowns never match
	task automatic cmp(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e) begin
			errors++;
			$display("unexpected at %0t: got %h wanted %h", $time, g, e);
		end
	endtask
	task automatic w(input int n);
		repeat (n) @(posedge clk);
	endtask
	// Classic cycle; waits for ack without assuming its latency
	task automatic wb(input logic wr, input logic [7:0] a,
		input logic [31:0] d);
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= wr;
		adr <= a;
		dwr <= d;
		sel <= 4'hF;
		do begin
			@(posedge clk);
		end while (ack !== 1'b1);
		rdat = dato;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	task automatic sel_all(input logic [7:0] code);
		for (int j = 0; j < 4; j++) wb(1'b1, 8'(4 * j), {24'h0, code});
		w(8);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_reset();
		cmp(term_out, 4'h0);
		wb(1'b0, OFS_RELAY_ONE, 0);
		cmp(rdat, 32'h00);
		wb(1'b0, OFS_RELAY_TWO, 0);
		cmp(rdat, 32'h0B);
		wb(1'b0, OFS_OC_ONE, 0);
		cmp(rdat, 32'h01);
		wb(1'b0, OFS_OC_TWO, 0);
		cmp(rdat, 32'h02);
		wb(1'b0, 8'hFC, 0);
		cmp(rdat, 32'h0);
	endtask
	task automatic t_codes();
		for (int i = 0; i < 9; i++) begin
			sts <= 9'h1 << i;
			sel_all(CD[i]);
			cmp(term_out, 4'hF);
			sts <= ~(9'h1 << i);
			sel_all(CD[i] + OUT_INVERT);
			cmp(term_out, 4'hF);
		end
		sts <= 9'h1FF;
		sel_all(8'h07);
		cmp(term_out, 4'h0);
		sel_all(8'h6B);
		cmp(term_out, 4'h0);
		sts <= 9'h0;
		sel_all(OUT_RUN);
	endtask
	task automatic t_enable();
		wb(1'b1, OFS_IN_SEL_LO, 32'h003F4500);
		term_in <= 8'h04;
		w(8);
		cmp(disabled_indication, 1'b1);
		run_cmd <= 1'b1;
		w(8);
		cmp(run_permit, 1'b0);
		term_in <= 8'h06;
		w(8);
		cmp({disabled_indication, run_permit}, 2'b00);
		run_cmd <= 1'b0;
		w(24);
		run_cmd <= 1'b1;
		w(8);
		cmp({run_permit, speed_search_from_cmd}, 2'b11);
		cmp(term_out[0], 1'b1);
		term_in <= 8'h04;
		w(8);
		cmp({stop_request, run_permit}, 2'b10);
		run_cmd <= 1'b0;
		w(30);
		cmp({stop_request, term_out[0]}, 2'b00);
	endtask
	task automatic t_lock();
		wb(1'b1, OFS_IN_SEL_LO, 32'h3C);
		term_in <= 8'h00;
		w(8);
		wb(1'b1, OFS_RELAY_ONE, 32'h05);
		wb(1'b0, OFS_RELAY_ONE, 0);
		cmp(rdat, 32'h0);
		wb(1'b1, OFS_FREQ_MON, 32'h1234);
		wb(1'b0, OFS_FREQ_MON, 0);
		cmp(rdat, 32'h1234);
		term_in <= 8'h01;
		w(8);
		wb(1'b1, OFS_RELAY_ONE, 32'h05);
		wb(1'b0, OFS_RELAY_ONE, 0);
		cmp(rdat, 32'h05);
		wb(1'b1, OFS_RELAY_ONE, 32'h0);
		wb(1'b1, OFS_IN_SEL_LO, 32'h0);
	endtask
	task automatic t_hold();
		wb(1'b1, OFS_IN_SEL_HI, {16'h0, IN_OFFSET_ONE, IN_ANALOG_HOLD});
		w(8);
		cmp(hold_conflict_error, 1'b1);
		wb(1'b1, OFS_IN_SEL_HI, {24'h0, IN_ANALOG_HOLD});
		w(8);
		cmp(hold_conflict_error, 1'b0);
		analog_input_one <= 12'h100;
		analog_input_two <= 12'h023;
		term_in <= 8'h10;
		w(40);
		analog_input_one <= 12'h200;
		w(8);
		cmp(freq_command, 16'h0123);
		power_loss <= 1'b1;
		w(3);
		cmp(freq_command, 16'h0000);
		power_loss <= 1'b0;
		term_in <= 8'h00;
	endtask
	task automatic t_torque();
		wb(1'b1, OFS_IN_SEL_HI, {IN_ZERO_SERVO, IN_TQ_SWITCH, 16'h0});
		w(8);
		cmp(control_method_error, 1'b1);
		wb(1'b1, OFS_CTRL, 32'h138);
		wb(1'b1, OFS_CTRL, 32'h13C);
		wb(1'b1, OFS_SW_DELAY, 32'h4);
		w(8);
		cmp({control_method_error, torque_mode}, 2'b00);
		cmp({stopping_method_select, buffering_method_select}, 4'hA);
		term_in <= 8'hC0;
		w(7);
		cmp(ref_hold, 1'b1);
		w(13);
		cmp(torque_mode, 1'b1);
		run_cmd <= 1'b1;
		w(8);
		cmp(zero_servo_request, 1'b1);
		run_cmd <= 1'b0;
		w(3);
		cmp(zero_servo_request, 1'b0);
	endtask
	////////////////////////////////////////////////////////////////////////
	// Verdict and end of run
	task automatic report_and_stop();
		$display("errors %0d checks %0d", errors, checks_done);
		if (errors == 0 && checks_done > 0) $display("*** PASS ***");
		else $display("*** FAIL ***");
		$finish;
	endtask
	initial begin
		#100000;
		errors++;
		report_and_stop();
	end
	initial begin
		{reset, ce, cyc, stb, we, run_cmd, jog_cmd} = 7'b1100000;
		{dc_braking, zero_servo_done, power_loss} = 3'b000;
		{dwr, adr, sel, term_in, sts} = '0;
		analog_input_one = 12'h0;
		analog_input_two = 12'h0;
		errors = 0;
		checks_done = 0;
		w(20);
		reset <= 1'b0;
		t_reset();
		t_codes();
		t_enable();
		t_lock();
		t_hold();
		t_torque();
		report_and_stop();
	end
endmodule
`default_nettype wire
